/* File: rtl/sfc_consts.svh */
`ifndef SFC_CONSTS_SVH
`define SFC_CONSTS_SVH
// control word layout
`define SFC_CW_BITS 72
`define SFC_CNT_W 7
`define SFC_A_W 6
`define SFC_N_W 12
`define SFC_M_W 10
`define SFC_A0_LSB 0
`define SFC_N0_LSB 6
`define SFC_M0_LSB 18
`define SFC_A1_LSB 28
`define SFC_N1_LSB 34
`define SFC_M1_LSB 46
`define SFC_TSEL_LSB 56
`define SFC_PWR_LSB 59
`define SFC_GAIN_BIT 62
`define SFC_FSK_LSB 63
`define SFC_TX_BIT 65
`define SFC_PUMP_HI_BIT 70
`define SFC_PUMP_LO_BIT 71
`define SFC_TSEL_DUAL 3'b110
// host register map (byte addresses)
`define SFC_REG_CTRL 8'h00
`define SFC_REG_STATUS 8'h04
`define SFC_REG_WORD0 8'h08
`define SFC_REG_WORD1 8'h0c
`define SFC_REG_WORD2 8'h10
`define SFC_REG_TXDATA 8'h14
`define SFC_CTRL_GO 0
`define SFC_TXD_BIT 0
`define SFC_TXD_DRIVE 1
// serial clock half period in aclk cycles
`define SFC_SCLK_HALF 8'h04
`define SFC_RESP_OK 2'b00
`define SFC_RESP_ERR 2'b10
`endif

/* File: rtl/sfc_pkg.sv */
package sfc_pkg;
`include "sfc_consts.svh"
  typedef enum logic [1:0]
  {
    FSK_VCO = 2'b00,
    FSK_DIVSW = 2'b01,
    FSK_INCDEC = 2'b10,
    FSK_OPEN = 2'b11
  } sfc_fsk_e;
  typedef enum logic [0:0]
  {
    HS_IDLE = 1'b0,
    HS_SHIFT = 1'b1
  } sfc_hstate_e;
  typedef logic [`SFC_CW_BITS-1:0] sfc_word_t;
  typedef struct packed {
    logic [1:0] sclk_q;
    logic sclk_d;
    logic [1:0] sdata_q;
    logic [1:0] pin_q;
    logic [1:0] hoe_q;
    logic [1:0] lock_q;
    logic [1:0] rx_q;
    logic [`SFC_CNT_W-1:0] bitcnt;
    sfc_word_t shreg;
    sfc_word_t word;
    logic mod_started;
    logic pump_high;
    logic pump_hiz;
    logic damp_oe;
    logic quad_oe;
    logic test_en;
    logic mod_en;
    logic mod_source;
    logic [`SFC_A_W-1:0] swallow;
    logic [`SFC_N_W-1:0] main;
    logic [`SFC_M_W-1:0] ref_div;
    logic [2:0] power;
    logic bypass;
    logic tx;
    logic locked;
    logic dout;
    logic doe;
  } sfc_dev_s;
  typedef struct packed {
    sfc_hstate_e st;
    sfc_word_t word;
    sfc_word_t shreg;
    logic [`SFC_CNT_W-1:0] bitcnt;
    logic [7:0] divcnt;
    logic sclk;
    logic sdata;
    logic sent_tx;
    logic tx_bit;
    logic drive;
    logic data_o;
    logic data_oe;
    logic [1:0] lock_q;
    logic [1:0] pin_q;
    logic aw_rdy;
    logic bvalid;
    logic [1:0] bresp;
    logic ar_rdy;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } sfc_host_s;
endpackage

/* File: rtl/sfc_link_if.sv */
`timescale 1ns/10ps
interface sfc_link_if;
  logic sclk;
  logic sdata;
  logic host_data;
  logic host_data_oe;
  logic dev_data;
  logic dev_data_oe;
  logic lock_ind;
  logic pin_level;
  // resolved level of the shared data pin, pulled low when nobody drives
  assign pin_level = host_data_oe ? host_data : (dev_data_oe & dev_data);
  modport dev
  (
    input sclk, sdata, host_data_oe, pin_level,
    output dev_data, dev_data_oe, lock_ind
  );
  modport host
  (
    input lock_ind, pin_level,
    output sclk, sdata, host_data, host_data_oe
  );
endinterface

/* File: rtl/sfc_device.sv */
`timescale 1ns/10ps
// Notes on behaviour
// - pump mode bits sit at 70, 71
// - mode 00: constant low pump current
// - mode 01: constant high pump current
// - mode 10: high unlocked, low locked
// - mode 11: lock-driven in tx, high in rx
// - damping switch on during fast-lock high current
// - lock returns low current, releases damping switch
// - two divider sets; set 0 in receive
// - divider switching: data selects set
// - inc/dec: set-1 swallow divider plus/minus one
// - host loads set 1 before transmitting
// - tx data taken from shared data pin
// - host keeps pin undriven until sending
// - modulation output sources on one, sinks zero
// - quad pin switch follows dual-filter control, in tx only
// - host programs test select to 110
// - dual-filter use blocks receiver test outputs
// - open loop tristates pump output
// - loop opens only when modulation starts
// - three-bit field picks eight power levels
// - gain bit zero bypasses pa buffer
// - lock output high while pll locked
module sfc_device
  import sfc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  sfc_link_if.dev link,
  input wire logic pll_lock_raw,
  input wire logic rx_data_raw,
  input wire logic pa_on,
  output logic pump_high,
  output logic pump_hiz,
  output logic fastlock_damping_switch_oe,
  output logic quad_test_out_oe,
  output logic test_out_en,
  output logic mod_en,
  output logic mod_source,
  output logic [`SFC_A_W-1:0] swallow_div,
  output logic [`SFC_N_W-1:0] main_div,
  output logic [`SFC_M_W-1:0] ref_div,
  output logic [2:0] tx_power_level,
  output logic buffer_bypass,
  output logic tx_mode
);

  sfc_dev_s r;
  sfc_dev_s next_r;

  ////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb
  begin
    logic pump_mode_hi;
    logic pump_mode_lo;
    logic lock_driven;
    logic data;
    logic rise;
    sfc_fsk_e fsk;
    logic [2:0] test_sel;
    logic [`SFC_A_W-1:0] a1;
    pump_mode_hi = r.word[`SFC_PUMP_HI_BIT];
    pump_mode_lo = r.word[`SFC_PUMP_LO_BIT];
    fsk = sfc_fsk_e'(r.word[`SFC_FSK_LSB +: 2]);
    test_sel = r.word[`SFC_TSEL_LSB +: 3];
    a1 = r.word[`SFC_A1_LSB +: `SFC_A_W];
    data = r.pin_q[1];
    next_r = r;
    // every pin input except pa_on passes two flops before use
    next_r.sclk_q = {r.sclk_q[0], link.sclk};
    next_r.sdata_q = {r.sdata_q[0], link.sdata};
    next_r.pin_q = {r.pin_q[0], link.pin_level};
    next_r.hoe_q = {r.hoe_q[0], link.host_data_oe};
    next_r.lock_q = {r.lock_q[0], pll_lock_raw};
    next_r.rx_q = {r.rx_q[0], rx_data_raw};
    next_r.sclk_d = r.sclk_q[1];
    rise = r.sclk_q[1] & ~r.sclk_d;
    // serial word: msb first, applied once all bits are in
    if (rise)
    begin
      next_r.shreg = {r.shreg[`SFC_CW_BITS-2:0], r.sdata_q[1]};
      if (r.bitcnt == `SFC_CNT_W'(`SFC_CW_BITS - 1))
      begin
        next_r.bitcnt = '0;
        next_r.word = {r.shreg[`SFC_CW_BITS-2:0], r.sdata_q[1]};
      end
      else
      begin
        next_r.bitcnt = r.bitcnt + `SFC_CNT_W'(1);
      end
    end
    next_r.locked = r.lock_q[1];
    next_r.tx = r.word[`SFC_TX_BIT];
    // pump current selection
    // mode 11 follows lock only in tx
    lock_driven = pump_mode_hi & (~pump_mode_lo | r.tx);
    if (!pump_mode_hi)
    begin
      next_r.pump_high = pump_mode_lo;
    end
    else if (lock_driven)
    begin
      next_r.pump_high = ~r.lock_q[1];
    end
    else
    begin
      next_r.pump_high = 1'b1;
    end
    // damping resistor only while fast lock is pushing high current
    next_r.damp_oe = lock_driven & ~r.lock_q[1];
    // open loop: closed until lock and pa on, opens when data starts
    if (!r.tx || fsk != FSK_OPEN)
    begin
      next_r.mod_started = 1'b0;
    end
    else if (r.lock_q[1] && pa_on && r.hoe_q[1])
    begin
      next_r.mod_started = 1'b1;
    end
    next_r.pump_hiz = r.mod_started;
    // dual loop filter switch; test outputs lose receiver signals
    next_r.quad_oe = (test_sel == `SFC_TSEL_DUAL) & r.tx;
    next_r.test_en = (test_sel != `SFC_TSEL_DUAL);
    // vco modulation current
    next_r.mod_en = r.tx & (fsk == FSK_VCO);
    next_r.mod_source = data;
    // divider set selection, set 0 whenever receiving
    if (!r.tx || (fsk == FSK_DIVSW && !data))
    begin
      next_r.swallow = r.word[`SFC_A0_LSB +: `SFC_A_W];
      next_r.main = r.word[`SFC_N0_LSB +: `SFC_N_W];
      next_r.ref_div = r.word[`SFC_M0_LSB +: `SFC_M_W];
    end
    else
    begin
      // set 1 is expected to hold the tx frequency here
      next_r.swallow = a1;
      if (fsk == FSK_INCDEC)
      begin
        next_r.swallow = data ? a1 + `SFC_A_W'(1)
                              : a1 - `SFC_A_W'(1);
      end
      next_r.main = r.word[`SFC_N1_LSB +: `SFC_N_W];
      next_r.ref_div = r.word[`SFC_M1_LSB +: `SFC_M_W];
    end
    next_r.power = r.word[`SFC_PWR_LSB +: 3];
    next_r.bypass = ~r.word[`SFC_GAIN_BIT];
    // received data goes out on the pin only while receiving
    next_r.doe = ~r.tx;
    next_r.dout = r.rx_q[1];
  end

  ////////////////////////////////////////////////////////////////////////
  // state register; all-zero word means rx, low pump current
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      r <= '0;
    end
    else if (ce)
    begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs straight from state
  assign pump_high = r.pump_high;
  assign pump_hiz = r.pump_hiz;
  assign fastlock_damping_switch_oe = r.damp_oe;
  assign quad_test_out_oe = r.quad_oe;
  assign test_out_en = r.test_en;
  assign mod_en = r.mod_en;
  assign mod_source = r.mod_source;
  assign swallow_div = r.swallow;
  assign main_div = r.main;
  assign ref_div = r.ref_div;
  assign tx_power_level = r.power;
  assign buffer_bypass = r.bypass;
  assign tx_mode = r.tx;
  assign link.dev_data = r.dout;
  assign link.dev_data_oe = r.doe;
  assign link.lock_ind = r.locked;

endmodule

/* File: rtl/sfc_host.sv */
// The placing of the registers and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/10ps
module sfc_host
  import sfc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  sfc_link_if.host link,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  sfc_host_s r;
  sfc_host_s next_r;

  // byte-strobe merge of one bus word
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        res[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    logic wr;
    logic go;
    logic [95:0] wide;
    wide = {24'h000000, r.word};
    go = 1'b0;
    next_r = r;
    next_r.lock_q = {r.lock_q[0], link.lock_ind};
    next_r.pin_q = {r.pin_q[0], link.pin_level};
    // write: address and data taken together, one at a time
    wr = r.aw_rdy & s_axi_awvalid & s_axi_wvalid;
    next_r.aw_rdy = ~r.aw_rdy & ~r.bvalid & s_axi_awvalid & s_axi_wvalid;
    if (wr)
    begin
      next_r.bvalid = 1'b1;
      next_r.bresp = `SFC_RESP_OK;
      unique case (s_axi_awaddr)
        `SFC_REG_CTRL: go = s_axi_wstrb[0] & s_axi_wdata[`SFC_CTRL_GO];
        `SFC_REG_STATUS: next_r.bresp = `SFC_RESP_ERR;
        `SFC_REG_WORD0: wide[31:0] = merge(wide[31:0], s_axi_wdata,
                                           s_axi_wstrb);
        `SFC_REG_WORD1: wide[63:32] = merge(wide[63:32], s_axi_wdata,
                                            s_axi_wstrb);
        `SFC_REG_WORD2: wide[95:64] = merge(wide[95:64], s_axi_wdata,
                                            s_axi_wstrb);
        `SFC_REG_TXDATA:
        begin
          if (s_axi_wstrb[0])
          begin
            next_r.tx_bit = s_axi_wdata[`SFC_TXD_BIT];
            next_r.drive = s_axi_wdata[`SFC_TXD_DRIVE];
          end
        end
        default: next_r.bresp = `SFC_RESP_ERR;
      endcase
      // the word cannot change under a transfer in progress
      if (r.st == HS_IDLE)
      begin
        next_r.word = wide[`SFC_CW_BITS-1:0];
      end
    end
    else if (r.bvalid && s_axi_bready)
    begin
      next_r.bvalid = 1'b0;
    end
    // read path
    next_r.ar_rdy = ~r.ar_rdy & ~r.rvalid & s_axi_arvalid;
    if (r.ar_rdy && s_axi_arvalid)
    begin
      next_r.rvalid = 1'b1;
      next_r.rresp = `SFC_RESP_OK;
      unique case (s_axi_araddr)
        `SFC_REG_CTRL: next_r.rdata = 32'h00000000;
        `SFC_REG_STATUS: next_r.rdata = {28'h0000000, r.sent_tx,
                                         r.pin_q[1], r.lock_q[1],
                                         r.st == HS_SHIFT};
        `SFC_REG_WORD0: next_r.rdata = wide[31:0];
        `SFC_REG_WORD1: next_r.rdata = wide[63:32];
        `SFC_REG_WORD2: next_r.rdata = wide[95:64];
        `SFC_REG_TXDATA: next_r.rdata = {30'h0, r.drive, r.tx_bit};
        default:
        begin
          next_r.rdata = 32'h00000000;
          next_r.rresp = `SFC_RESP_ERR;
        end
      endcase
    end
    else if (r.rvalid && s_axi_rready)
    begin
      next_r.rvalid = 1'b0;
    end
    // serial sender: data set with clock low, device samples on rise
    unique case (r.st)
      HS_IDLE:
      begin
        next_r.sclk = 1'b0;
        if (go)
        begin
          next_r.st = HS_SHIFT;
          next_r.shreg = r.word;
          next_r.sdata = r.word[`SFC_CW_BITS-1];
          next_r.bitcnt = '0;
          next_r.divcnt = '0;
        end
      end
      HS_SHIFT:
      begin
        next_r.divcnt = r.divcnt + 8'h01;
        if (r.divcnt == `SFC_SCLK_HALF - 8'h01)
        begin
          next_r.divcnt = '0;
          next_r.sclk = ~r.sclk;
          if (r.sclk)
          begin
            next_r.shreg = {r.shreg[`SFC_CW_BITS-2:0], 1'b0};
            next_r.sdata = r.shreg[`SFC_CW_BITS-2];
            next_r.bitcnt = r.bitcnt + `SFC_CNT_W'(1);
            if (r.bitcnt == `SFC_CNT_W'(`SFC_CW_BITS - 1))
            begin
              next_r.st = HS_IDLE;
              next_r.sent_tx = r.word[`SFC_TX_BIT];
            end
          end
        end
      end
    endcase
    // pin stays undriven until software asks to send in tx
    next_r.data_oe = r.drive & r.sent_tx;
    next_r.data_o = r.tx_bit;
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      r <= '0;
    end
    else if (ce)
    begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign s_axi_awready = r.aw_rdy;
  assign s_axi_wready = r.aw_rdy;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_arready = r.ar_rdy;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rresp = r.rresp;
  assign s_axi_rdata = r.rdata;
  assign link.sclk = r.sclk;
  assign link.sdata = r.sdata;
  assign link.host_data = r.data_o;
  assign link.host_data_oe = r.data_oe;

endmodule

/* File: dv/sfc_link_monitor.sv */
`timescale 1ns/10ps
module sfc_link_monitor
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sclk,
  input wire logic sdata,
  input wire logic host_data,
  input wire logic host_data_oe,
  input wire logic dev_data,
  input wire logic dev_data_oe,
  input wire logic lock_ind,
  input wire logic pin_level
);
  logic sclk_q;
  logic [3:0] idle_cnt;
  logic [6:0] rise_cnt;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  ////////////////////////////////////////////////////////////////////////
  // low time of the serial clock and rising edges within one frame;
  // idle_cnt saturates so long gaps between frames stay cheap
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sclk_q <= 1'b0;
      idle_cnt <= 4'h0;
      rise_cnt <= 7'h00;
    end
    else
    begin
      sclk_q <= sclk;
      idle_cnt <= sclk ? 4'h0
                  : (idle_cnt == 4'hf ? idle_cnt : idle_cnt + 4'h1);
      if (sclk && !sclk_q)
        rise_cnt <= (rise_cnt == 7'd71) ? 7'h00 : rise_cnt + 7'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // serial framing and pin ownership
  sclk_high_width_a: assert property (
    $rose(sclk) |-> sclk[*4] ##1 !sclk)
    else $error("serial clock high phase not four cycles");
  sclk_low_width_a: assert property (
    $fell(sclk) |-> !sclk[*4])
    else $error("serial clock low phase too short");
  sdata_hold_a: assert property (
    $changed(sdata) |-> !sclk)
    else $error("serial data moved while clock high");
  frame_length_a: assert property (
    idle_cnt == 4'd6 |-> rise_cnt == 7'd0)
    else $error("frame ended off a 72 bit boundary");
  pin_owner_a: assert property (
    host_data_oe |-> !dev_data_oe)
    else $error("both ends drive the shared pin");
  rx_drive_reset_a: assert property (
    $rose(aresetn) |=> dev_data_oe)
    else $error("device not driving pin after reset");
  dir_frame_end_a: assert property (
    $changed(dev_data_oe) |-> rise_cnt == 7'd0)
    else $error("pin direction changed inside a frame");
  quiet_start_a: assert property (
    $rose(aresetn) |-> !sclk[*2])
    else $error("serial clock active right after reset");

  cover property ($fell(dev_data_oe));
  cover property (host_data_oe && host_data);
  cover property (dev_data_oe && dev_data && pin_level);
  cover property ($rose(lock_ind));
endmodule

/* File: dv/synth_pump_fsk_control_bench.sv */
`timescale 1ns/10ps
`include "sfc_consts.svh"
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin miscompares++; \
  $display("[ERR] %0t got %h want %h", $time, a, e); end end
`define WAIT(c) wcnt = 0; do @(posedge aclk); while (!(c) && wcnt++ < 2000); \
  if (!(c)) begin miscompares++; give_verdict(); end
module synth_pump_fsk_control_bench
  import sfc_pkg::*;
;
  localparam logic [5:0] SW0 = 6'h05;
  localparam logic [11:0] MD0 = 12'h123;
  localparam logic [9:0] RD0 = 10'h0a1;
  localparam logic [5:0] SW1 = 6'h2a;
  localparam logic [11:0] MD1 = 12'h3c4;
  localparam logic [9:0] RD1 = 10'h155;
  logic aclk, aresetn, ce, pll_lock_raw, rx_data_raw, pa_on;
  logic pump_high, pump_hiz, fastlock_damping_switch_oe, quad_test_out_oe;
  logic test_out_en, mod_en, mod_source, buffer_bypass, tx_mode;
  logic [`SFC_A_W-1:0] swallow_div;
  logic [`SFC_N_W-1:0] main_div;
  logic [`SFC_M_W-1:0] ref_div;
  logic [2:0] tx_power_level;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp, pm;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, tx, lk, d, hi, dmp;
  sfc_fsk_e f;
  int miscompares, checks_done, wcnt, i, j, k;

  sfc_link_if sfc_link_if_inst();
  sfc_device sfc_device_inst (.link(sfc_link_if_inst), .*);
  sfc_host sfc_host_inst (.link(sfc_link_if_inst), .*);
  sfc_link_monitor sfc_link_monitor_inst (.aclk(aclk), .aresetn(aresetn),
    .sclk(sfc_link_if_inst.sclk), .sdata(sfc_link_if_inst.sdata),
    .host_data(sfc_link_if_inst.host_data),
    .host_data_oe(sfc_link_if_inst.host_data_oe),
    .dev_data(sfc_link_if_inst.dev_data),
    .dev_data_oe(sfc_link_if_inst.dev_data_oe),
    .lock_ind(sfc_link_if_inst.lock_ind),
    .pin_level(sfc_link_if_inst.pin_level));

  ////////////////////////////////////////////////////////////////////////
  // 40 MHz clock
  initial
  begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // bready and rready stay high, so each answer is taken when it shows
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    `WAIT(s_axi_awready && s_axi_wready)
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    `WAIT(s_axi_bvalid)
    rsp = s_axi_bresp;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    `WAIT(s_axi_arready)
    s_axi_arvalid <= 1'b0;
    `WAIT(s_axi_rvalid)
    rdat = s_axi_rdata;
    rsp = s_axi_rresp;
  endtask

  function automatic sfc_word_t mk(input logic [1:0] m, input logic t,
    input sfc_fsk_e fm, input logic [2:0] ts, input logic [2:0] p,
    input logic g);
    return {m[0], m[1], 4'h0, t, fm, g, p, ts, RD1, MD1, SW1, RD0, MD0, SW0};
  endfunction

  // load the word, start the transfer, poll busy, let outputs settle
  task automatic send(input sfc_word_t w);
    wr(`SFC_REG_WORD0, w[31:0]);
    wr(`SFC_REG_WORD1, w[63:32]);
    wr(`SFC_REG_WORD2, {24'h0, w[71:64]});
    wr(`SFC_REG_CTRL, 32'h1);
    rdat = 32'h1;
    for (int n = 0; n < 400 && rdat[0]; n++)
      rd(`SFC_REG_STATUS);
    if (rdat[0])
    begin
      miscompares++;
      give_verdict();
    end
    repeat (8) @(posedge aclk);
  endtask

  task automatic divs(input logic s);
    `CHK(swallow_div, s ? SW1 : SW0);
    `CHK(main_div, s ? MD1 : MD0);
    `CHK(ref_div, s ? RD1 : RD0);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    {aresetn, pll_lock_raw, rx_data_raw, pa_on} = 4'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {ce, s_axi_bready, s_axi_rready, s_axi_wstrb} = 7'h7f;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    `CHK({tx_mode, pump_high, pump_hiz}, 3'b000);
    rd(8'h40);
    `CHK({rsp, rdat}, {`SFC_RESP_ERR, 32'h0});
    wr(`SFC_REG_STATUS, 32'h1);
    `CHK(rsp, `SFC_RESP_ERR);
    // every pump mode in both directions, every power level
    for (i = 0; i < 4; i++)
      for (j = 0; j < 2; j++)
      begin
        pm = i[1:0];
        tx = j[0];
        send(mk(pm, tx, FSK_VCO, pm == 2'd3 ? 3'b110 : 3'b000,
                {pm, tx}, tx));
        for (k = 0; k < 2; k++)
        begin
          lk = k[0];
          pll_lock_raw <= lk;
          repeat (8) @(posedge aclk);
          hi = (pm == 2'd1) || (pm == 2'd3 && !tx) || (pm[1] && !lk);
          dmp = pm[1] && !lk && !(pm == 2'd3 && !tx);
          `CHK(pump_high, hi);
          `CHK(pump_high, hi);
          `CHK(fastlock_damping_switch_oe, dmp);
          `CHK(sfc_link_if_inst.lock_ind, lk);
        end
        `CHK(tx_mode, tx);
        divs(tx);
        `CHK(tx_power_level, {pm, tx});
        `CHK(buffer_bypass, !tx);
        `CHK(quad_test_out_oe, pm == 2'd3 && tx);
        `CHK(test_out_en, pm != 2'd3);
        `CHK(sfc_link_if_inst.dev_data_oe, !tx);
      end
    // clock enable low freezes every register, then state moves again
    ce <= 1'b0;
    pll_lock_raw <= 1'b0;
    repeat (8) @(posedge aclk);
    `CHK(sfc_link_if_inst.lock_ind, 1'b1);
    ce <= 1'b1;
    repeat (8) @(posedge aclk);
    `CHK(sfc_link_if_inst.lock_ind, 1'b0);
    pll_lock_raw <= 1'b1;
    repeat (8) @(posedge aclk);
    `CHK(sfc_link_if_inst.lock_ind, 1'b1);
    // modulation methods driven from the shared pin
    for (i = 0; i < 3; i++)
    begin
      f = (i == 0) ? FSK_DIVSW : (i == 1) ? FSK_INCDEC : FSK_VCO;
      wr(`SFC_REG_TXDATA, 32'h0);
      send(mk(2'd0, 1'b1, f, 3'd0, 3'd0, 1'b1));
      `CHK(sfc_link_if_inst.host_data_oe, 1'b0);
      for (k = 0; k < 2; k++)
      begin
        d = k[0];
        wr(`SFC_REG_TXDATA, {30'h0, 1'b1, d});
        repeat (8) @(posedge aclk);
        if (i == 0) divs(d);
        if (i == 1)
          `CHK(swallow_div, d ? SW1 + 6'd1 : SW1 - 6'd1);
        if (i == 2) `CHK({mod_en, mod_source}, {1'b1, d});
        rd(`SFC_REG_STATUS);
        `CHK({rdat[2], sfc_link_if_inst.pin_level}, {d, d});
      end
    end
    // open loop waits for the amplifier before releasing the pump
    send(mk(2'd0, 1'b1, FSK_OPEN, 3'd0, 3'd0, 1'b1));
    `CHK(pump_hiz, 1'b0);
    pa_on <= 1'b1;
    repeat (8) @(posedge aclk);
    `CHK(pump_hiz, 1'b1);
    // back to receive: device drives demodulated data
    wr(`SFC_REG_TXDATA, 32'h0);
    pa_on <= 1'b0;
    rx_data_raw <= 1'b1;
    send(mk(2'd0, 1'b0, FSK_VCO, 3'd0, 3'd0, 1'b0));
    rd(`SFC_REG_STATUS);
    `CHK(rdat[3:1], 3'b011);
    `CHK(sfc_link_if_inst.pin_level, 1'b1);
    give_verdict();
  end
endmodule
